/* File: core/emtx_pkg.sv */
// Constants, register map and state encoding for the transmit path control block.
//
// Operation
// - Transmit enable high sends packets; low sends only idle characters.
// - FCS insertion high computes and appends FCS; low appends none.
// - Gap setting 8 to 12 gives average minimum gap in bytes, met with idles.
// - Gap setting 0 to 7 means only the terminate character between packets.
// - Send local fault emits local fault ordered sets, beating remote fault.
// - Send remote fault without local fault emits remote fault ordered sets.
// - Send idle high makes the transmit path emit only idle characters.
// - Custom preamble enable uses the preamble given with the packet.
// - Ignore FCS error only matters while FCS insertion is off.
// - Insertion off, ignore low: check each packet FCS, bad ones are not good.
// - Insertion off, ignore high: bad packet counted good, sent as is, flagged.
package emtx_pkg;

  // ------------------------
  // Register map
  // ------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0c;

  localparam int          CTL_TX_EN      = 0;
  localparam int          CTL_FCS_INS    = 1;
  localparam int          CTL_SEND_LF    = 2;
  localparam int          CTL_SEND_RF    = 3;
  localparam int          CTL_SEND_IDLE  = 4;
  localparam int          CTL_CUST_PRE   = 5;
  localparam int          CTL_IGN_FCS    = 6;
  localparam int          CTL_IPG_LO     = 8;
  localparam int          IPG_W          = 4;
  localparam logic [31:0] CTRL_RESET     = 32'h00000c02;
  localparam logic [31:0] CTRL_MASK      = 32'h00000f7f;

  localparam int          IRQ_PKT        = 0;
  localparam int          IRQ_BAD_FCS    = 1;
  localparam int          IRQ_FAULT      = 2;
  localparam int          IRQ_W          = 3;

  // ------------------------
  // Line characters and CRC
  // ------------------------
  localparam logic [7:0]  CH_IDLE        = 8'h07;
  localparam logic [7:0]  CH_START       = 8'hfb;
  localparam logic [7:0]  CH_TERM        = 8'hfd;
  localparam logic [7:0]  CH_ERR         = 8'hfe;
  localparam logic [7:0]  CH_SEQ         = 8'h9c;
  localparam logic [7:0]  CH_PRE         = 8'h55;
  localparam logic [7:0]  CH_SFD         = 8'hd5;
  localparam logic [7:0]  CH_ZERO        = 8'h00;
  localparam logic [7:0]  FAULT_LOCAL    = 8'h01;
  localparam logic [7:0]  FAULT_REMOTE   = 8'h02;
  localparam logic [3:0]  IPG_AVG_MIN    = 4'h8;
  localparam logic [3:0]  PRE_LAST       = 4'h7;
  localparam logic [3:0]  FCS_LAST       = 4'h3;
  localparam logic [3:0]  SEQ_LAST       = 4'h3;
  localparam logic [3:0]  CNT_ONE        = 4'h1;
  localparam logic [3:0]  CNT_ZERO       = 4'h0;
  localparam logic [31:0] CRC_INIT       = 32'hffffffff;
  localparam logic [31:0] CRC_POLY       = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE    = 32'hdebb20e3;

  // ------------------------
  // Transmit state, Gray coded along the packet path
  // ------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_DATA  = 3'b011,
    ST_FCS   = 3'b010,
    ST_TERM  = 3'b110,
    ST_GAP   = 3'b111,
    ST_FAULT = 3'b101
  } emtx_state_type;

endpackage : emtx_pkg

/* File: core/emtx_crc_if.sv */
// Interface between the transmit sequencer and its CRC engine.
`timescale 1ns/100ps
interface emtx_crc_if;
  logic        clear;
  logic        en;
  logic [7:0]  data;
  logic [31:0] value;

  modport client (output clear, output en, output data, input value);
  modport engine (input clear, input en, input data, output value);
endinterface : emtx_crc_if

/* File: core/emtx_crc32.sv */
// Byte-wide CRC-32 engine for frame check sequence generation and checking.
`timescale 1ns/100ps
module emtx_crc32 (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  emtx_crc_if.engine  crc
);

  logic [31:0] crc_q;

  function automatic logic [31:0] emtx_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ emtx_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : emtx_crc_byte

  // Clear wins over a byte in the same cycle: a new frame restarts the sum
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crc_q <= emtx_pkg::CRC_INIT;
    end else if (crc.clear) begin
      crc_q <= emtx_pkg::CRC_INIT;
    end else if (crc.en) begin
      crc_q <= emtx_crc_byte(crc_q, crc.data);
    end
  end

  assign crc.value = crc_q;

endmodule : emtx_crc32

/* File: core/emtx_tx_top.sv */
// Transmit path control: APB registers, frame sequencer, FCS handling and interrupts.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module emtx_tx_top #(
  parameter int LANES = 4
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Packet stream from user logic, one byte a cycle
  input  wire logic [7:0]            s_data,
  input  wire logic                  s_valid,
  input  wire logic                  s_last,
  input  wire logic [55:0]           s_preamble,
  output logic                       s_ready,
  // Line side character stream
  output logic      [7:0]            tx_data,
  output logic                       tx_ctrl,
  // Per-lane alignment markers
  input  wire logic [LANES*64-1:0]   lane_align_marker_value,
  output logic      [LANES*64-1:0]   lane_marker_out,
  // Per-packet statistics pulses and the interrupt output
  output logic                       stat_tx_packet,
  output logic                       stat_tx_good,
  output logic                       stat_tx_bad_fcs,
  output logic                       stat_tx_stomped_fcs,
  output logic                       irq
);

  // ------------------------
  // Declarations
  // ------------------------
  emtx_pkg::emtx_state_type state_q;
  emtx_pkg::emtx_state_type state_d;

  logic [31:0]             ctrl_q;
  logic [emtx_pkg::IRQ_W-1:0] irq_stat_q;
  logic [emtx_pkg::IRQ_W-1:0] irq_stat_d;
  logic [emtx_pkg::IRQ_W-1:0] irq_mask_q;
  logic [emtx_pkg::IRQ_W-1:0] irq_ev;
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic                    apb_wr;
  logic                    apb_rd;
  logic                    addr_ok;
  logic [31:0]             rd_mux;

  logic [3:0]              cnt_q;
  logic [3:0]              cnt_d;
  logic [55:0]             pre_q;
  logic                    fcs_ins_q;
  logic                    ign_fcs_q;
  logic                    cust_pre_q;
  logic [7:0]              fault_kind_q;
  logic [7:0]              fault_kind_d;
  logic [7:0]              out_d;
  logic                    ctl_d;
  logic                    start_pkt;
  logic                    start_fault;
  logic                    accept;
  logic                    crc_ok;
  logic [2:0]              pre_idx;
  logic [31:0]             fcs_inv;
  logic [3:0]              ipg;

  logic [7:0]              tx_data_q;
  logic                    tx_ctrl_q;
  logic                    s_ready_q;
  logic                    stat_pkt_q;
  logic                    stat_good_q;
  logic                    stat_bad_q;
  logic                    stat_stomp_q;
  logic                    irq_q;
  logic [LANES*64-1:0]     marker_q;

  emtx_crc_if              crc_bus ();

  emtx_crc32 u_crc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .crc     (crc_bus.engine)
  );

  // ------------------------
  // APB slave
  // ------------------------
  // Every access takes one wait state so that ready and data come from flops
  assign apb_wr  = psel & penable & pready_q & pwrite;
  assign apb_rd  = psel & penable & ~pready_q & ~pwrite;
  assign addr_ok = (paddr == emtx_pkg::ADDR_CTRL) | (paddr == emtx_pkg::ADDR_STATUS) |
                   (paddr == emtx_pkg::ADDR_IRQ_STAT) | (paddr == emtx_pkg::ADDR_IRQ_MASK);

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      emtx_pkg::ADDR_CTRL:     rd_mux = ctrl_q;
      emtx_pkg::ADDR_STATUS:   rd_mux = {28'h0000000, state_q, (state_q != emtx_pkg::ST_IDLE)};
      emtx_pkg::ADDR_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_q};
      emtx_pkg::ADDR_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_q};
      default:                 rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~addr_ok;
      if (apb_rd) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= emtx_pkg::CTRL_RESET;
      irq_mask_q <= 3'h0;
    end else if (apb_wr) begin
      if (paddr == emtx_pkg::ADDR_CTRL) begin
        ctrl_q <= pwdata & emtx_pkg::CTRL_MASK;
      end
      if (paddr == emtx_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= pwdata[emtx_pkg::IRQ_W-1:0];
      end
    end
  end

  assign ipg = ctrl_q[emtx_pkg::CTL_IPG_LO +: emtx_pkg::IPG_W];

  // ------------------------
  // Frame sequencer
  // ------------------------
  // Idle and enable outrank faults; local outranks remote
  assign start_fault = ctrl_q[emtx_pkg::CTL_TX_EN] & ~ctrl_q[emtx_pkg::CTL_SEND_IDLE] &
                       (ctrl_q[emtx_pkg::CTL_SEND_LF] | ctrl_q[emtx_pkg::CTL_SEND_RF]);
  assign start_pkt   = ctrl_q[emtx_pkg::CTL_TX_EN] & ~ctrl_q[emtx_pkg::CTL_SEND_IDLE] &
                       ~start_fault & s_valid;
  assign accept      = (state_q == emtx_pkg::ST_DATA) & s_valid & s_ready_q;
  assign pre_idx     = 3'(cnt_q - emtx_pkg::CNT_ONE);
  assign fcs_inv     = ~crc_bus.value;
  assign crc_ok      = (crc_bus.value == emtx_pkg::CRC_RESIDUE);

  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    fault_kind_d = fault_kind_q;
    out_d        = emtx_pkg::CH_IDLE;
    ctl_d        = 1'b1;
    case (state_q)
      emtx_pkg::ST_IDLE: begin
        // Start controls are only looked at here, between frames; the gap setting is read live in ST_TERM
        if (start_fault) begin
          out_d   = emtx_pkg::CH_SEQ;
          cnt_d   = emtx_pkg::CNT_ONE;
          state_d = emtx_pkg::ST_FAULT;
          fault_kind_d = ctrl_q[emtx_pkg::CTL_SEND_LF] ? emtx_pkg::FAULT_LOCAL
                                                       : emtx_pkg::FAULT_REMOTE;
        end else if (start_pkt) begin
          out_d   = emtx_pkg::CH_START;
          cnt_d   = emtx_pkg::CNT_ONE;
          state_d = emtx_pkg::ST_PRE;
        end
      end
      emtx_pkg::ST_PRE: begin
        ctl_d = 1'b0;
        if (cust_pre_q) begin
          out_d = pre_q[8*pre_idx +: 8];
        end else begin
          out_d = (cnt_q == emtx_pkg::PRE_LAST) ? emtx_pkg::CH_SFD : emtx_pkg::CH_PRE;
        end
        cnt_d = cnt_q + emtx_pkg::CNT_ONE;
        if (cnt_q == emtx_pkg::PRE_LAST) begin
          state_d = emtx_pkg::ST_DATA;
        end
      end
      emtx_pkg::ST_DATA: begin
        if (accept) begin
          out_d = s_data;
          ctl_d = 1'b0;
          if (s_last) begin
            cnt_d   = emtx_pkg::CNT_ZERO;
            state_d = fcs_ins_q ? emtx_pkg::ST_FCS : emtx_pkg::ST_TERM;
          end
        end else begin
          // Underrun inside a frame: mark the line with an error character
          out_d = emtx_pkg::CH_ERR;
        end
      end
      emtx_pkg::ST_FCS: begin
        ctl_d = 1'b0;
        out_d = fcs_inv[8*cnt_q[1:0] +: 8];
        cnt_d = cnt_q + emtx_pkg::CNT_ONE;
        if (cnt_q == emtx_pkg::FCS_LAST) begin
          state_d = emtx_pkg::ST_TERM;
        end
      end
      emtx_pkg::ST_TERM: begin
        out_d = emtx_pkg::CH_TERM;
        // Terminate counts as one gap byte; the rest are idles
        if (ipg >= emtx_pkg::IPG_AVG_MIN) begin
          cnt_d   = ipg - emtx_pkg::CNT_ONE;
          state_d = emtx_pkg::ST_GAP;
        end else begin
          state_d = emtx_pkg::ST_IDLE;
        end
      end
      emtx_pkg::ST_GAP: begin
        cnt_d = cnt_q - emtx_pkg::CNT_ONE;
        if (cnt_q == emtx_pkg::CNT_ONE) begin
          state_d = emtx_pkg::ST_IDLE;
        end
      end
      emtx_pkg::ST_FAULT: begin
        out_d = (cnt_q == emtx_pkg::SEQ_LAST) ? fault_kind_q : emtx_pkg::CH_ZERO;
        ctl_d = 1'b0;
        cnt_d = cnt_q + emtx_pkg::CNT_ONE;
        if (cnt_q == emtx_pkg::SEQ_LAST) begin
          state_d = emtx_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = emtx_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q      <= emtx_pkg::ST_IDLE;
      cnt_q        <= 4'h0;
      fault_kind_q <= 8'h00;
      tx_data_q    <= emtx_pkg::CH_IDLE;
      tx_ctrl_q    <= 1'b1;
      s_ready_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      fault_kind_q <= fault_kind_d;
      tx_data_q    <= out_d;
      tx_ctrl_q    <= ctl_d;
      s_ready_q    <= (state_d == emtx_pkg::ST_DATA) & ~(accept & s_last);
    end
  end

  // Per-frame settings are frozen at the start character
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_q      <= 56'h00000000000000;
      fcs_ins_q  <= 1'b0;
      ign_fcs_q  <= 1'b0;
      cust_pre_q <= 1'b0;
    end else if ((state_q == emtx_pkg::ST_IDLE) & ~start_fault & start_pkt) begin
      pre_q      <= s_preamble;
      fcs_ins_q  <= ctrl_q[emtx_pkg::CTL_FCS_INS];
      ign_fcs_q  <= ctrl_q[emtx_pkg::CTL_IGN_FCS];
      cust_pre_q <= ctrl_q[emtx_pkg::CTL_CUST_PRE];
    end
  end

  assign crc_bus.clear = (state_q == emtx_pkg::ST_IDLE) & start_pkt;
  assign crc_bus.en    = accept;
  assign crc_bus.data  = s_data;

  // ------------------------
  // FCS check and statistics
  // ------------------------
  // With insertion off the user frame carries its own FCS, so the CRC
  // over the whole frame must land on the fixed residue
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_pkt_q   <= 1'b0;
      stat_good_q  <= 1'b0;
      stat_bad_q   <= 1'b0;
      stat_stomp_q <= 1'b0;
    end else begin
      stat_pkt_q   <= (state_q == emtx_pkg::ST_TERM);
      stat_good_q  <= (state_q == emtx_pkg::ST_TERM) &
                      (fcs_ins_q | crc_ok | ign_fcs_q);
      stat_bad_q   <= (state_q == emtx_pkg::ST_TERM) & ~fcs_ins_q & ~crc_ok;
      stat_stomp_q <= (state_q == emtx_pkg::ST_TERM) & ~fcs_ins_q & ~crc_ok &
                      ign_fcs_q;
    end
  end

  // ------------------------
  // Interrupts
  // ------------------------
  assign irq_ev[emtx_pkg::IRQ_PKT]     = (state_q == emtx_pkg::ST_TERM);
  assign irq_ev[emtx_pkg::IRQ_BAD_FCS] = (state_q == emtx_pkg::ST_TERM) & ~fcs_ins_q & ~crc_ok;
  assign irq_ev[emtx_pkg::IRQ_FAULT]   = (state_q == emtx_pkg::ST_IDLE) & start_fault;

  // A new event in the clearing cycle survives the write of one
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (apb_wr & (paddr == emtx_pkg::ADDR_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~pwdata[emtx_pkg::IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_ev;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ------------------------
  // Lane alignment markers
  // ------------------------
  // Cleared in reset; after that each lane's value is registered from the input on every clock
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        marker_q[g*64 +: 64] <= 64'h0000000000000000;
      end else begin
        marker_q[g*64 +: 64] <= lane_align_marker_value[g*64 +: 64];
      end
    end
  end

  // ------------------------
  // Outputs
  // ------------------------
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign s_ready             = s_ready_q;
  assign tx_data             = tx_data_q;
  assign tx_ctrl             = tx_ctrl_q;
  assign lane_marker_out     = marker_q;
  assign stat_tx_packet      = stat_pkt_q;
  assign stat_tx_good        = stat_good_q;
  assign stat_tx_bad_fcs     = stat_bad_q;
  assign stat_tx_stomped_fcs = stat_stomp_q;
  assign irq                 = irq_q;

endmodule : emtx_tx_top

/* File: verif/emtx_tx_top_assertions.sv */
// Port-level checks for the transmit path control block.
`timescale 1ns/100ps
module emtx_tx_top_assertions #(
  parameter int LANES = 4
) (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [7:0]           s_data,
  input wire logic                 s_valid,
  input wire logic                 s_ready,
  input wire logic [7:0]           tx_data,
  input wire logic                 tx_ctrl,
  input wire logic [LANES*64-1:0]  lane_align_marker_value,
  input wire logic [LANES*64-1:0]  lane_marker_out,
  input wire logic                 stat_tx_packet,
  input wire logic                 stat_tx_good,
  input wire logic                 stat_tx_bad_fcs,
  input wire logic                 stat_tx_stomped_fcs
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire is_term = tx_ctrl && tx_data == emtx_pkg::CH_TERM;
  wire is_seq  = tx_ctrl && tx_data == emtx_pkg::CH_SEQ;

  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  byte_pass_a: assert property (s_valid && s_ready |=> !tx_ctrl && tx_data == $past(s_data))
    else $error("accepted byte not sent");
  frame_end_a: assert property (is_term |-> stat_tx_packet ##1 tx_ctrl &&
    (tx_data == emtx_pkg::CH_IDLE || tx_data == emtx_pkg::CH_START || tx_data == emtx_pkg::CH_SEQ))
    else $error("bad frame end");
  start_pre_a: assert property (tx_ctrl && tx_data == emtx_pkg::CH_START |=> (!tx_ctrl) [*7])
    else $error("preamble broken");
  fault_set_a: assert property (is_seq |=> (!tx_ctrl && tx_data == emtx_pkg::CH_ZERO) [*2] ##1
    (tx_data == emtx_pkg::FAULT_LOCAL || tx_data == emtx_pkg::FAULT_REMOTE))
    else $error("fault set broken");
  stomp_good_a: assert property (stat_tx_stomped_fcs |-> stat_tx_bad_fcs && stat_tx_good)
    else $error("stomped not good");
  bad_not_good_a: assert property (stat_tx_bad_fcs && !stat_tx_stomped_fcs |-> !stat_tx_good)
    else $error("bad counted good");
  marker_copy_a: assert property (!$past(rst) |-> lane_marker_out == $past(lane_align_marker_value))
    else $error("marker not copied");

  cover property (is_term);
  cover property (stat_tx_stomped_fcs);
  cover property (is_seq);
  cover property (pslverr);
endmodule : emtx_tx_top_assertions

bind emtx_tx_top emtx_tx_top_assertions #(.LANES(LANES)) i_emtx_tx_top_assertions (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .s_data(s_data), .s_valid(s_valid), .s_ready(s_ready), .tx_data(tx_data), .tx_ctrl(tx_ctrl),
  .lane_align_marker_value(lane_align_marker_value), .lane_marker_out(lane_marker_out),
  .stat_tx_packet(stat_tx_packet), .stat_tx_good(stat_tx_good), .stat_tx_bad_fcs(stat_tx_bad_fcs),
  .stat_tx_stomped_fcs(stat_tx_stomped_fcs));

/* File: verif/emtx_src_model.sv */
// Packet source standing in for the user logic on the stream side.
`timescale 1ns/100ps
module emtx_src_model (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         s_ready,
  input  wire logic         go,
  input  wire logic [3:0]   len,
  input  wire logic [1:0]   nfr,
  input  wire logic [127:0] frm,
  output logic      [7:0]   s_data,
  output logic              s_valid,
  output logic              s_last
);
  logic [3:0] idx_q;
  logic [1:0] left_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idx_q  <= 4'h0;
      left_q <= 2'h0;
    end else if (go && left_q == 2'h0) begin
      left_q <= nfr;
    end else if (s_valid && s_ready) begin
      idx_q  <= s_last ? 4'h0 : idx_q + 4'h1;
      left_q <= left_q - {1'b0, s_last};
    end
  end
  // Valid stays up across frames: a mid-frame hole is sent as an error
  assign s_valid = left_q != 2'h0;
  assign s_last  = s_valid && idx_q == len - 4'h1;
  // Off-frame data inverted so a stale byte never looks good
  assign s_data  = s_valid ? frm[8*idx_q+:8] : ~frm[7:0];
endmodule : emtx_src_model

/* File: verif/emtx_tx_top_tb_top.sv */
// Self-checking bench for the transmit path control block.
`timescale 1ns/100ps
module emtx_tx_top_tb_top;
  logic         sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0]   paddr = 8'h00, s_data, tx_data, flt = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata, rd_q;
  logic         pready, pslverr, s_valid, s_last, s_ready, tx_ctrl, irq, e_q, st_p, st_g, st_b, st_s;
  logic [55:0]  pre = 56'hd5_5555_5555_5555;
  logic [255:0] lav = {4{64'h0123_4567_89ab_cdef}};
  logic [127:0] frm = '0, fr;
  logic [3:0]   len = 4'h4;
  logic [1:0]   nfr = 2'h1, k_g;
  logic [7:0]   cap [$];
  logic         rec = 1'b0;
  int err_total, n_compared, cyc, np, ng, nb, ns, nni, gap, gp, sq, n_g, p0;
  localparam logic [7:0] A_CT = emtx_pkg::ADDR_CTRL, A_IS = emtx_pkg::ADDR_IRQ_STAT, A_IM = emtx_pkg::ADDR_IRQ_MASK;
  logic [3:0]  ipg_t [4] = '{4'h0, 4'h7, 4'h8, 4'hc};
  logic [31:0] fc_c [4] = '{32'h0c01, 32'h0c01, 32'h0c41, 32'h0c43};
  logic        fc_b [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int          fc_x [4] = '{4, 2, 7, 4};
  logic [31:0] fl_c [3] = '{32'h0c0f, 32'h0c0b, 32'h0c17};
  int          fl_x [3] = '{1, 2, 0};

  emtx_tx_top i_emtx_tx_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .s_data(s_data),
    .s_valid(s_valid), .s_last(s_last), .s_preamble(pre), .s_ready(s_ready), .tx_data(tx_data),
    .tx_ctrl(tx_ctrl), .lane_align_marker_value(lav), .lane_marker_out(), .stat_tx_packet(st_p),
    .stat_tx_good(st_g), .stat_tx_bad_fcs(st_b), .stat_tx_stomped_fcs(st_s), .irq(irq));
  emtx_src_model i_emtx_src_model (.sys_clk(sys_clk), .rst(rst), .s_ready(s_ready), .go(go), .len(len),
    .nfr(nfr), .frm(frm), .s_data(s_data), .s_valid(s_valid), .s_last(s_last));

  always #50 sys_clk = ~sys_clk;

  // ------------------------
  // Line monitor, sampled mid-cycle where outputs are settled
  // ------------------------
  always @(negedge sys_clk) begin
    np += st_p;
    ng += st_g;
    nb += st_b;
    ns += st_s;
    if (!(tx_ctrl && tx_data == emtx_pkg::CH_IDLE)) nni++;
    else gp++;
    if (tx_ctrl && tx_data == emtx_pkg::CH_START) begin
      cap = {};
      rec = 1'b1;
      gap = gp;
    end
    if (rec) cap.push_back(tx_data);
    if (tx_ctrl && tx_data == emtx_pkg::CH_TERM) begin
      rec = 1'b0;
      gp = 0;
    end
    sq = (tx_ctrl && tx_data == emtx_pkg::CH_SEQ) ? 1 : (sq > 0 ? sq + 1 : 0);
    if (sq == 4) flt = tx_data;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("counts: %0d compared, %0d mismatches", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_q = prdata;
    e_q  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(rd_q, x);
    chk({31'h0, e_q}, {31'h0, xe});
  endtask : rd

  function automatic logic [31:0] crc_f(input logic [127:0] f, input int n);
    logic [31:0] c;
    c = emtx_pkg::CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c ^= {24'h0, f[8*i+:8]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ emtx_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc_f

  // Bench copy carries the FCS; the source gets it only with insertion off
  task automatic send(input int n, input logic [1:0] k, input logic ins, input logic bad);
    fr = '0;
    for (int i = 0; i < n; i++) fr[8*i+:8] = 8'h10 + 8'(i);
    fr[8*n+:32] = crc_f(fr, n) ^ {31'h0, bad};
    n_g = n;
    k_g = k;
    p0  = np;
    @(posedge sys_clk);
    frm <= ins ? fr & ~(128'hffffffff << 8 * n) : fr;
    len <= ins ? 4'(n) : 4'(n + 4);
    nfr <= k;
    go  <= 1'b1;
    @(posedge sys_clk);
    go  <= 1'b0;
  endtask : send

  task automatic fin();
    repeat (400) if (np < p0 + k_g) @(posedge sys_clk);
    chk(np, p0 + k_g);
    chk(cap.size(), n_g + 13);
    for (int i = 0; i < n_g + 13; i++)
      chk({24'h0, cap[i]}, {24'h0, i == 0 ? emtx_pkg::CH_START : i < 8 ? pre[8*i-8+:8] :
        i < n_g + 12 ? fr[8*i-64+:8] : emtx_pkg::CH_TERM});
  endtask : fin

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(A_CT, emtx_pkg::CTRL_RESET, 1'b0);
    rd(A_IS, 32'h0, 1'b0);
    apb(1'b1, 8'h20, 32'hffffffff);
    chk({31'h0, e_q}, 32'h1);
    rd(8'h20, 32'h0, 1'b1);
    apb(1'b1, A_IM, 32'h7);
    $display("register test done");
    nni = 0;
    send(4, 2'h1, 1'b1, 1'b0);
    repeat (30) @(posedge sys_clk);
    chk(nni, 0);
    apb(1'b1, A_CT, 32'h0c03);
    fin();
    rd(A_IS, 32'h1, 1'b0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_IS, 32'h1);
    rd(A_IS, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    $display("enable test done");
    foreach (ipg_t[j]) begin
      apb(1'b1, A_CT, {20'h0, ipg_t[j], 8'h03});
      send(4, 2'h2, 1'b1, 1'b0);
      fin();
      chk(gap, ipg_t[j] < 4'h8 ? 0 : ipg_t[j] - 1);
    end
    $display("gap test done");
    foreach (fc_c[j]) begin
      apb(1'b1, A_CT, fc_c[j]);
      ng = 0;
      nb = 0;
      ns = 0;
      send(4, 2'h1, fc_c[j][1], fc_b[j]);
      fin();
      chk(ng * 4 + nb * 2 + ns, fc_x[j]);
    end
    rd(A_IS, 32'h3, 1'b0);
    apb(1'b1, A_IS, 32'h7);
    $display("fcs test done");
    pre <= 56'hd5_a6a5_a4a3_a2a1;
    apb(1'b1, A_CT, 32'h0c23);
    send(4, 2'h1, 1'b1, 1'b0);
    fin();
    pre <= 56'hd5_5555_5555_5555;
    $display("preamble test done");
    foreach (fl_c[j]) begin
      apb(1'b1, A_CT, fl_c[j]);
      repeat (8) @(posedge sys_clk);
      flt = 8'h00;
      nni = 0;
      repeat (20) @(posedge sys_clk);
      chk({24'h0, flt}, fl_x[j]);
      chk(nni, fl_x[j] == 0 ? 0 : 20);
    end
    send(4, 2'h1, 1'b1, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(nni, 0);
    rd(A_IS, 32'h5, 1'b0);
    apb(1'b1, A_IM, 32'h2);
    rd(A_IM, 32'h2, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, A_IS, 32'h4);
    apb(1'b1, A_CT, 32'h0c03);
    fin();
    $display("fault test done");
    send(8, 2'h1, 1'b1, 1'b0);
    repeat (12) @(posedge sys_clk);
    apb(1'b1, A_CT, 32'h0c02);
    fin();
    $display("boundary test done");
    end_sim();
  end
endmodule : emtx_tx_top_tb_top
